/* File: core/sqc_pkg.sv */
// Contract
// - Large variant has five strobes, one per pod.
// - Small variant has two strobes, pods one, two.
// - Each strobe qualifier: fall, rise, either, high, low, off.
// - Sample clock is OR(edges) AND OR(levels).
// - No edge selected: reject and flag error.
// - Per-pod mode: normal, demultiplex or mixed.
// - Mode selector exists for every assigned pod.
// - Normal mode samples all assigned pods together.
// - Demultiplex: slave takes bits 0-7, master again.
// - Demultiplex ignores the upper eight data lines.
// - Identical arrangements still capture slave then master.
// - Mixed: low byte on slave, high on master.
// - Ranges may overlap or nest; exact bounds.
// - Strobe uses the same threshold as its pod.
// - Label bits packed from LSB, at most 32.
package sqc_pkg;

    // Documented pod and label geometry
    localparam int POD_WIDTH    = 16;  // Data lines per pod
    localparam int BYTE_WIDTH   = 8;   // Half-pod width used by two-phase modes
    localparam int LABEL_MAX    = 32;  // Most channels one label may hold
    localparam int LABEL_CNT_W  = 8;   // Width of the label channel counter
    localparam int PODS_LARGE   = 5;   // Strobes on the large variant
    localparam int PODS_SMALL   = 2;   // Strobes on the small variant
    localparam int QUAL_W       = 3;   // Bits per strobe qualifier
    localparam int MODE_W       = 2;   // Bits per pod capture mode
    localparam int THRESH_W     = 2;   // Bits per pod threshold select

    // Strobe qualifier codes; unused codes behave as off
    typedef enum logic [QUAL_W-1:0] {
        Q_OFF    = 3'h0,
        Q_FALL   = 3'h1,
        Q_RISE   = 3'h2,
        Q_EITHER = 3'h3,
        Q_HIGH   = 3'h4,
        Q_LOW    = 3'h5
    } qual_e;

    // Pod capture modes
    typedef enum logic [MODE_W-1:0] {
        M_NORMAL = 2'h0,
        M_DEMUX  = 2'h1,
        M_MIXED  = 2'h2
    } mode_e;

    // Two-phase sequencer, Gray along slave -> master -> slave
    typedef enum logic [1:0] {
        PH_SLAVE  = 2'h0,
        PH_MASTER = 2'h1
    } phase_e;

    // Values after reset
    localparam logic [POD_WIDTH-1:0] REC_RST   = 16'h0000;
    localparam logic [BYTE_WIDTH-1:0] BYTE_RST = 8'h00;
    localparam logic [THRESH_W-1:0] THR_RST    = 2'h0;

endpackage

/* File: core/arrangement_if.sv */
`timescale 1ns/1ps
// Synchronised strobe view in, one arrangement verdict out
interface arrangement_if #(parameter int N = 5);
    logic [N-1:0]          lvl;      // Strobe level after synchroniser
    logic [N-1:0]          rise;     // One-cycle rising edge
    logic [N-1:0]          fall;     // One-cycle falling edge
    logic [3*N-1:0]        qual;     // Qualifier per strobe
    logic                  hit;      // Arrangement satisfied this cycle
    logic                  no_edge;  // No edge term selected

    modport eval (
        input  lvl,
        input  rise,
        input  fall,
        input  qual,
        output hit,
        output no_edge
    );
    modport user (
        output lvl,
        output rise,
        output fall,
        output qual,
        input  hit,
        input  no_edge
    );
endinterface

/* File: core/arrangement_eval.sv */
`timescale 1ns/1ps
// Evaluates one clocking arrangement over all strobes
module arrangement_eval
    import sqc_pkg::*;
#(
    parameter int N = PODS_LARGE
) (
    arrangement_if.eval a
);

    logic [N-1:0] edge_term;  // Per-strobe selected edge seen
    logic [N-1:0] lvl_term;   // Per-strobe selected level true
    logic [N-1:0] edge_sel;   // Strobe set to an edge qualifier
    logic [N-1:0] lvl_sel;    // Strobe set to a level qualifier

    ////////////////////////////////////////////////////////////////////////
    // Per-strobe qualifier decode
    for (genvar i = 0; i < N; i++) begin : g_strobe
        qual_e q;
        assign q = qual_e'(a.qual[QUAL_W*i +: QUAL_W]);
        // Six-way qualifier; unknown codes fall to off
        always_comb begin
            edge_term[i] = 1'b0;
            lvl_term[i]  = 1'b0;
            edge_sel[i]  = 1'b0;
            lvl_sel[i]   = 1'b0;
            case (q)
                Q_FALL: begin
                    edge_sel[i]  = 1'b1;
                    edge_term[i] = a.fall[i];
                end
                Q_RISE: begin
                    edge_sel[i]  = 1'b1;
                    edge_term[i] = a.rise[i];
                end
                Q_EITHER: begin
                    edge_sel[i]  = 1'b1;
                    edge_term[i] = a.rise[i] | a.fall[i];
                end
                Q_HIGH: begin
                    lvl_sel[i]  = 1'b1;
                    lvl_term[i] = a.lvl[i];
                end
                Q_LOW: begin
                    lvl_sel[i]  = 1'b1;
                    lvl_term[i] = ~a.lvl[i];
                end
                default: begin
                    edge_term[i] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combination; with no level selected the level side is true
    assign a.no_edge = ~|edge_sel;
    assign a.hit     = |edge_term & (~|lvl_sel | |lvl_term) & ~a.no_edge;

endmodule

/* File: core/state_sample_clock_qualifier.sv */
`timescale 1ns/1ps
// State-capture sample qualifier: strobes from the target clock the data
module state_sample_clock_qualifier
    import sqc_pkg::*;
#(
    parameter int NUM_PODS   = PODS_LARGE,  // Five on the large part, two on the small
    parameter int NUM_RANGES = 2            // Symbol range comparators
) (
    input  wire logic                            clock,
    input  wire logic                            rstn,
    input  wire logic [NUM_PODS-1:0]             strobe_pin,
    input  wire logic [NUM_PODS*POD_WIDTH-1:0]   pod_data_pin,
    input  wire logic [NUM_PODS*QUAL_W-1:0]      main_qual,
    input  wire logic [NUM_PODS*QUAL_W-1:0]      slave_qual,
    input  wire logic [NUM_PODS*QUAL_W-1:0]      master_qual,
    input  wire logic [NUM_PODS*MODE_W-1:0]      pod_mode,
    input  wire logic [NUM_PODS-1:0]             pod_assign,
    input  wire logic [NUM_PODS*THRESH_W-1:0]    pod_thresh,
    input  wire logic [NUM_PODS*POD_WIDTH-1:0]   label_mask,
    input  wire logic [NUM_RANGES*LABEL_MAX-1:0] range_lo,
    input  wire logic [NUM_RANGES*LABEL_MAX-1:0] range_hi,
    output logic [NUM_PODS*POD_WIDTH-1:0]        record_q,
    output logic                                 record_valid_q,
    output logic [LABEL_MAX-1:0]                 label_q,
    output logic [NUM_RANGES-1:0]                range_hit_q,
    output logic                                 label_over_q,
    output logic                                 clock_cfg_error_q,
    output logic                                 master_wait_q,
    output logic [NUM_PODS*THRESH_W-1:0]         pod_thresh_q
);

    localparam int NB = NUM_PODS * POD_WIDTH;  // Total data lines

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds only stage two
    logic [NUM_PODS-1:0] strobe_s1_q;  // First stage, metastable
    logic [NUM_PODS-1:0] strobe_s2_q;  // Stable strobe level
    logic [NUM_PODS-1:0] strobe_s3_q;  // Previous level for edges
    logic [NB-1:0]       data_s1_q;    // First stage, metastable
    logic [NB-1:0]       data_s2_q;    // Stable data, aligned with strobe_s2_q

    // Strobes and data cross together so an edge sees its own data
    always_ff @(posedge clock) begin
        if (!rstn) begin
            strobe_s1_q <= '0;
            strobe_s2_q <= '0;
            strobe_s3_q <= '0;
            data_s1_q   <= '0;
            data_s2_q   <= '0;
        end else begin
            strobe_s1_q <= strobe_pin;
            strobe_s2_q <= strobe_s1_q;
            strobe_s3_q <= strobe_s2_q;
            data_s1_q   <= pod_data_pin;
            data_s2_q   <= data_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Three arrangements: single-phase, slave and master
    arrangement_if #(.N(NUM_PODS)) arr_main ();
    arrangement_if #(.N(NUM_PODS)) arr_slave ();
    arrangement_if #(.N(NUM_PODS)) arr_master ();

    logic [NUM_PODS-1:0] s_rise;  // Edge pulses from the stable stages
    logic [NUM_PODS-1:0] s_fall;
    assign s_rise = strobe_s2_q & ~strobe_s3_q;
    assign s_fall = ~strobe_s2_q & strobe_s3_q;

    assign arr_main.lvl    = strobe_s2_q;
    assign arr_main.rise   = s_rise;
    assign arr_main.fall   = s_fall;
    assign arr_main.qual   = main_qual;
    assign arr_slave.lvl   = strobe_s2_q;
    assign arr_slave.rise  = s_rise;
    assign arr_slave.fall  = s_fall;
    assign arr_slave.qual  = slave_qual;
    assign arr_master.lvl  = strobe_s2_q;
    assign arr_master.rise = s_rise;
    assign arr_master.fall = s_fall;
    assign arr_master.qual = master_qual;

    arrangement_eval #(.N(NUM_PODS)) u_eval_main (
        .a (arr_main.eval)
    );
    arrangement_eval #(.N(NUM_PODS)) u_eval_slave (
        .a (arr_slave.eval)
    );
    arrangement_eval #(.N(NUM_PODS)) u_eval_master (
        .a (arr_master.eval)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode summary across assigned pods
    logic two_phase;  // Some assigned pod uses slave/master
    logic cfg_err;    // Active arrangement lacks an edge

    // Modes on unassigned pods have no effect
    always_comb begin
        two_phase = 1'b0;
        for (int p = 0; p < NUM_PODS; p++) begin
            if (pod_assign[p] && mode_e'(pod_mode[MODE_W*p +: MODE_W]) != M_NORMAL) begin
                two_phase = 1'b1;
            end
        end
    end

    // Only the arrangements actually in use are checked
    assign cfg_err = two_phase ? (arr_slave.no_edge | arr_master.no_edge)
                               : arr_main.no_edge;

    // Error flag is a live view of the configuration
    always_ff @(posedge clock) begin
        if (!rstn) begin
            clock_cfg_error_q <= 1'b0;
        end else begin
            clock_cfg_error_q <= cfg_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slave/master sequencer
    phase_e phase_q;  // Which arrangement is awaited
    logic   slave_take;  // Slave arrangement captured now
    logic   commit;      // Record completes this cycle

    assign slave_take = two_phase && !cfg_err && phase_q == PH_SLAVE && arr_slave.hit;
    // Single phase commits on the main arrangement; two-phase on master
    assign commit = !cfg_err && (two_phase ? (phase_q == PH_MASTER && arr_master.hit)
                                           : arr_main.hit);

    // A hit consumed by the slave never also serves the master
    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase_q <= PH_SLAVE;
        end else if (cfg_err || !two_phase) begin
            phase_q <= PH_SLAVE;  // A configuration error or single-phase setup restarts the pair
        end else begin
            case (phase_q)
                PH_SLAVE: begin
                    if (arr_slave.hit) begin
                        phase_q <= PH_MASTER;
                    end
                end
                PH_MASTER: begin
                    if (arr_master.hit) begin
                        phase_q <= PH_SLAVE;
                    end
                end
                default: begin
                    phase_q <= PH_SLAVE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            master_wait_q <= 1'b0;
        end else begin
            master_wait_q <= two_phase && !cfg_err &&
                             (phase_q == PH_MASTER ? !arr_master.hit : slave_take);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pod capture
    logic [NB-1:0] record_d;  // Record assembled for this commit

    for (genvar p = 0; p < NUM_PODS; p++) begin : g_pod
        logic [BYTE_WIDTH-1:0] slave_byte_q;  // Low byte held from slave phase
        logic [POD_WIDTH-1:0]  pd;            // Synchronised pod data
        mode_e                 md;            // Pod capture mode
        assign pd = data_s2_q[POD_WIDTH*p +: POD_WIDTH];
        assign md = mode_e'(pod_mode[MODE_W*p +: MODE_W]);

        // Lower eight lines latched when the slave arrangement fires
        always_ff @(posedge clock) begin
            if (!rstn) begin
                slave_byte_q <= BYTE_RST;
            end else if (slave_take) begin
                slave_byte_q <= pd[BYTE_WIDTH-1:0];
            end
        end

        // Master-phase half placed above the slave half
        always_comb begin
            case (md)
                M_DEMUX: begin
                    // Upper lines are never read here
                    record_d[POD_WIDTH*p +: POD_WIDTH] =
                        {pd[BYTE_WIDTH-1:0], slave_byte_q};
                end
                M_MIXED: begin
                    record_d[POD_WIDTH*p +: POD_WIDTH] =
                        {pd[POD_WIDTH-1:BYTE_WIDTH], slave_byte_q};
                end
                default: begin
                    record_d[POD_WIDTH*p +: POD_WIDTH] = pd;
                end
            endcase
            if (!pod_assign[p]) begin
                record_d[POD_WIDTH*p +: POD_WIDTH] = REC_RST;
            end
        end

        // Strobe and data comparators share one threshold selection
        always_ff @(posedge clock) begin
            if (!rstn) begin
                pod_thresh_q[THRESH_W*p +: THRESH_W] <= THR_RST;
            end else begin
                pod_thresh_q[THRESH_W*p +: THRESH_W] <= pod_thresh[THRESH_W*p +: THRESH_W];
            end
        end
    end

    // Record register; holds between commits
    always_ff @(posedge clock) begin
        if (!rstn) begin
            record_q       <= '0;
            record_valid_q <= 1'b0;
        end else begin
            record_valid_q <= commit;
            if (commit) begin
                record_q <= record_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Label packing: assigned lines numbered from the lowest upward
    logic [LABEL_MAX-1:0]   label_d;  // Packed label of the next record
    logic [LABEL_CNT_W-1:0] lcnt;     // Assigned line count
    logic                   label_over;  // More lines than a label holds

    // Lines past the limit are dropped rather than wrapped
    always_comb begin
        label_d = '0;
        lcnt    = '0;
        for (int b = 0; b < NB; b++) begin
            if (label_mask[b]) begin
                if (lcnt < LABEL_CNT_W'(LABEL_MAX)) begin
                    label_d[lcnt[4:0]] = record_d[b];
                end
                lcnt = lcnt + 8'h01;
            end
        end
        label_over = lcnt > LABEL_CNT_W'(LABEL_MAX);
    end

    ////////////////////////////////////////////////////////////////////////
    // Symbol ranges: inclusive, exact bounds; overlaps are independent
    logic [NUM_RANGES-1:0] range_hit_d;  // Per-range match of label_d
    for (genvar r = 0; r < NUM_RANGES; r++) begin : g_range
        assign range_hit_d[r] = label_d >= range_lo[LABEL_MAX*r +: LABEL_MAX] &&
                                label_d <= range_hi[LABEL_MAX*r +: LABEL_MAX];
    end

    // Label and matches follow the record they describe
    always_ff @(posedge clock) begin
        if (!rstn) begin
            label_q     <= '0;
            range_hit_q <= '0;
        end else if (commit) begin
            label_q     <= label_d;
            range_hit_q <= range_hit_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            label_over_q <= 1'b0;
        end else begin
            label_over_q <= label_over;
        end
    end

endmodule

/* File: tb/target_model.sv */
`timescale 1ns/1ps
// Behavioural target system: drives strobes and pod data lines
module target_model
    import sqc_pkg::*;
#(
    parameter int N = PODS_SMALL
) (
    output logic [N-1:0]           strobe_pin,
    output logic [N*POD_WIDTH-1:0] pod_data_pin
);
    // Strobes idle low, data idle before the first frame
    initial begin
        strobe_pin   = '0;
        pod_data_pin = '0;
    end

    // One 160 ns link frame; strobe stands still outside it
    task automatic step(input logic [N-1:0] s, input logic [N*POD_WIDTH-1:0] d);
        pod_data_pin = d;     // Data valid well ahead of the edge
        #43;
        strobe_pin = s;       // Off the system clock edge, always 3 ns after a rising one
        #80;
        pod_data_pin = ~d;    // Hold over: stale value must not be reused
        #37;
    endtask
endmodule

/* File: tb/sqc_sva.sv */
`timescale 1ns/1ps
// Port-level watch on the qualifier outputs
module sqc_sva
    import sqc_pkg::*;
#(
    parameter int NUM_PODS = PODS_LARGE
) (
    input wire logic                          clock,
    input wire logic                          rstn,
    input wire logic [NUM_PODS*QUAL_W-1:0]    main_qual,
    input wire logic [NUM_PODS*QUAL_W-1:0]    slave_qual,
    input wire logic [NUM_PODS*QUAL_W-1:0]    master_qual,
    input wire logic [NUM_PODS*MODE_W-1:0]    pod_mode,
    input wire logic [NUM_PODS-1:0]           pod_assign,
    input wire logic [NUM_PODS*THRESH_W-1:0]  pod_thresh,
    input wire logic [NUM_PODS*POD_WIDTH-1:0] label_mask,
    input wire logic [NUM_PODS*POD_WIDTH-1:0] record_q,
    input wire logic                          record_valid_q,
    input wire logic [LABEL_MAX-1:0]          label_q,
    input wire logic                          clock_cfg_error_q,
    input wire logic                          master_wait_q,
    input wire logic [NUM_PODS*THRESH_W-1:0]  pod_thresh_q
);
    logic                          two_ph;   // Some assigned pod is two-phase
    logic                          err_exp;  // Arrangement in use has no edge
    logic [NUM_PODS*POD_WIDTH-1:0] amask;    // Lines of assigned pods
    logic [LABEL_MAX-1:0]          lab;      // Label packed from the record

    ////////////////////////////////////////////////
    // Reference view of the configuration pins
    always_comb begin
        int   k;
        logic me;
        logic se;
        logic ce;
        two_ph = 1'b0;
        me = 1'b0;
        se = 1'b0;
        ce = 1'b0;
        amask = '0;
        lab = '0;
        k = 0;
        for (int p = 0; p < NUM_PODS; p++) begin
            if (pod_assign[p] && pod_mode[p*MODE_W +: MODE_W] inside {M_DEMUX, M_MIXED})
                two_ph = 1'b1;
            if (pod_assign[p])
                amask[p*POD_WIDTH +: POD_WIDTH] = '1;
            me |= main_qual[p*QUAL_W +: QUAL_W] inside {Q_FALL, Q_RISE, Q_EITHER};
            se |= slave_qual[p*QUAL_W +: QUAL_W] inside {Q_FALL, Q_RISE, Q_EITHER};
            ce |= master_qual[p*QUAL_W +: QUAL_W] inside {Q_FALL, Q_RISE, Q_EITHER};
        end
        // Scan from bit 0; anything past the label limit is dropped
        for (int b = 0; b < NUM_PODS*POD_WIDTH; b++) begin
            if (label_mask[b] && k < LABEL_MAX) begin
                lab[k] = record_q[b];
                k = k + 1;
            end
        end
        err_exp = two_ph ? !(se && ce) : !me;
    end

    ////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // Waiting phase ends while still two-phase and legal
    sequence s_wait_end;
        master_wait_q ##1 (!master_wait_q && two_ph && !clock_cfg_error_q);
    endsequence

    pulse_once_a: assert property (record_valid_q |=> !record_valid_q)
        else $error("record valid held longer than one cycle");
    err_blocks_a: assert property (clock_cfg_error_q |-> !record_valid_q && !master_wait_q)
        else $error("capture while edge-less arrangement flagged");
    err_follow_a: assert property ($past(rstn) && $past(rstn, 2) |->
        clock_cfg_error_q == $past(err_exp))
        else $error("configuration error flag wrong");
    thresh_copy_a: assert property ($past(rstn) && $past(rstn, 2) |->
        pod_thresh_q == $past(pod_thresh))
        else $error("threshold copy wrong");
    commit_order_a: assert property (record_valid_q && two_ph |-> $past(master_wait_q))
        else $error("two-phase record without slave capture");
    wait_commit_a: assert property (s_wait_end |-> record_valid_q)
        else $error("master wait ended without a record");
    single_nowait_a: assert property (!two_ph && !$past(two_ph) && !$past(two_ph, 2)
        |-> !master_wait_q)
        else $error("single phase waiting for master");
    unassigned_zero_a: assert property (record_valid_q |-> (record_q & ~amask) == '0)
        else $error("unassigned pod bits in record");
    label_pack_a: assert property (record_valid_q |-> label_q == lab)
        else $error("label not packed from lowest assigned bit");
endmodule

bind state_sample_clock_qualifier sqc_sva #(.NUM_PODS(NUM_PODS)) sqc_sva_i (
    .clock, .rstn, .main_qual, .slave_qual, .master_qual, .pod_mode, .pod_assign,
    .pod_thresh, .label_mask, .record_q, .record_valid_q, .label_q, .clock_cfg_error_q,
    .master_wait_q, .pod_thresh_q
);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// Bench for the two-pod qualifier
module tb_top
    import sqc_pkg::*;
;
    localparam int NP = PODS_SMALL;  // Small variant
    logic        clock;
    logic        rstn;
    logic [1:0]  strobe_pin;
    logic [31:0] pod_data_pin;
    logic [5:0]  main_qual;
    logic [5:0]  slave_qual;
    logic [5:0]  master_qual;
    logic [3:0]  pod_mode;
    logic [1:0]  pod_assign;
    logic [3:0]  pod_thresh;
    logic [31:0] label_mask;
    logic [63:0] range_lo;
    logic [63:0] range_hi;
    logic [31:0] record_q;
    logic        record_valid_q;
    logic [31:0] label_q;
    logic [1:0]  range_hit_q;
    logic        label_over_q;
    logic        clock_cfg_error_q;
    logic        master_wait_q;
    logic [3:0]  pod_thresh_q;
    int          err_count = 0;
    int          n_compared = 0;
    int          n_rec = 0;    // Records seen
    logic [31:0] rec;          // Last record seen

    state_sample_clock_qualifier #(.NUM_PODS(NP), .NUM_RANGES(2)) state_sample_clock_qualifier_i (
        .clock, .rstn, .strobe_pin, .pod_data_pin, .main_qual, .slave_qual, .master_qual,
        .pod_mode, .pod_assign, .pod_thresh, .label_mask, .range_lo, .range_hi, .record_q,
        .record_valid_q, .label_q, .range_hit_q, .label_over_q, .clock_cfg_error_q,
        .master_wait_q, .pod_thresh_q
    );
    target_model #(.N(NP)) target_model_i (.strobe_pin, .pod_data_pin);

    ////////////////////////////////////////////////
    // Clock and record monitor
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (record_valid_q === 1'b1) begin
            n_rec <= n_rec + 1;
            rec   <= record_q;
        end
    end

    ////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reconfigure only between frames, then let flags settle
    task automatic cfg(input logic [5:0] mq, input logic [5:0] sq, input logic [5:0] cq,
                       input logic [3:0] md);
        @(posedge clock);
        main_qual   <= mq;
        slave_qual  <= sq;
        master_qual <= cq;
        pod_mode    <= md;
        repeat (3) @(posedge clock);
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////
    // Scenarios
    task automatic t_quals();
        logic [2:0] c;
        int         n;
        for (int i = 1; i < 4; i++) begin
            c = 3'(i);
            cfg({Q_OFF, c}, 6'h00, 6'h00, 4'h0);
            n = n_rec;
            target_model_i.step(2'b01, 32'h1234_A5C3);
            target_model_i.step(2'b00, 32'hBEEF_0F1E);
            check(n_rec - n, int'(c != Q_FALL) + int'(c != Q_RISE));
            check(rec, (c == Q_RISE) ? 32'h1234_A5C3 : 32'hBEEF_0F1E);
        end
        $display("qualifier test done");
    endtask

    // Rise on pod 1 gated by high, then low, on pod 2
    task automatic t_level();
        logic [1:0] s [8] = '{2'b01, 2'b11, 2'b10, 2'b11, 2'b10, 2'b11, 2'b00, 2'b01};
        int         n;
        cfg({Q_HIGH, Q_RISE}, 6'h00, 6'h00, 4'h0);
        pod_thresh <= 4'h9;
        n = n_rec;
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                check(rec, 32'h3);
                cfg({Q_LOW, Q_RISE}, 6'h00, 6'h00, 4'h0);
            end
            target_model_i.step(s[i], 32'(i));
        end
        check(n_rec - n, 32'h2);
        check(rec, 32'h7);
        check({28'h0, pod_thresh_q}, 32'h9);
        $display("level test done");
    endtask

    // Levels only: flagged, nothing taken
    task automatic t_noedge();
        int n;
        cfg({Q_LOW, Q_HIGH}, 6'h00, 6'h00, 4'h0);
        n = n_rec;
        check({31'h0, clock_cfg_error_q}, 32'h1);
        target_model_i.step(2'b00, 32'hA);
        target_model_i.step(2'b01, 32'hB);
        check(n_rec - n, 32'h0);
        cfg({Q_OFF, Q_FALL}, 6'h00, 6'h00, 4'h0);
        check({31'h0, clock_cfg_error_q}, 32'h0);
        $display("no-edge test done");
    endtask

    // Demultiplex on pod 1, then mixed on pod 2 with equal arrangements
    task automatic t_two_phase();
        logic [3:0]  md [2] = '{4'h1, 4'h8};
        logic [2:0]  sq [2] = '{Q_RISE, Q_EITHER};
        logic [2:0]  cq [2] = '{Q_FALL, Q_EITHER};
        logic [31:0] ex [2] = '{32'h9696_1E3C, 32'h965A_E11E};
        int          n;
        for (int i = 0; i < 2; i++) begin
            cfg(6'h00, {Q_OFF, sq[i]}, {Q_OFF, cq[i]}, md[i]);
            n = n_rec;
            target_model_i.step(2'b00, 32'h0);
            target_model_i.step(2'b01, 32'h5A5A_C33C);
            check({31'h0, master_wait_q}, 32'h1);
            target_model_i.step(2'b00, 32'h9696_E11E);
            check(n_rec - n, 32'h1);
            check(rec, ex[i]);
            check({31'h0, master_wait_q}, 32'h0);
        end
        $display("two-phase test done");
    endtask

    // Unassigned pod, packed label, exact and nested ranges
    task automatic t_label();
        cfg({Q_OFF, Q_FALL}, 6'h00, 6'h00, 4'h0);
        pod_assign <= 2'b01;
        label_mask <= 32'h0001_F00F;
        range_lo   <= {32'h0000_0000, 32'h0000_00AA};
        range_hi   <= {32'hFFFF_FFFF, 32'h0000_00AA};
        target_model_i.step(2'b01, 32'h0);
        target_model_i.step(2'b00, 32'hFFFF_A55A);
        check(rec, 32'h0000_A55A);
        check(label_q, 32'h0000_00AA);
        check({30'h0, range_hit_q}, 32'h3);
        check({31'h0, label_over_q}, 32'h0);
        $display("label test done");
    endtask

    ////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        rstn = 1'b0;
        main_qual = 6'h00;
        slave_qual = 6'h00;
        master_qual = 6'h00;
        pod_mode = 4'h0;
        pod_assign = 2'h3;
        pod_thresh = 4'h0;
        label_mask = 32'hFFFF_FFFF;
        range_lo = 64'h0;
        range_hi = 64'h0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        t_quals();
        t_level();
        t_noedge();
        t_two_phase();
        t_label();
        results();
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("ERROR at %0t: got %h expected %h", $time, 32'h0, 32'h1);
        results();
    end
endmodule
